// File: hdl/saf_pkg.sv
// Shared constants, register map and types of the serial framing block
package saf_pkg;

  // Timing
  localparam int unsigned CLK_HZ        = 100_000_000;
  localparam int unsigned US_PER_S      = 1_000_000;
  localparam int unsigned MS_PER_S      = 1_000;
  localparam int unsigned HOLD_UNIT_US  = 1;
  localparam int unsigned LIMIT_UNIT_MS = 1;
  localparam int unsigned CYC_PER_US    = CLK_HZ / US_PER_S * HOLD_UNIT_US;
  localparam int unsigned CYC_PER_MS    = CLK_HZ / MS_PER_S * LIMIT_UNIT_MS;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_PRIM_LO  = 8'h07;
  localparam logic [7:0] IDX_SILENCE  = 8'h09;
  localparam logic [7:0] IDX_FLAGS    = 8'h0B;
  localparam logic [7:0] IDX_HOLD     = 8'h5E;
  localparam logic [7:0] IDX_PRIM_HI  = 8'h69;
  localparam logic [7:0] IDX_SEC_LO   = 8'h6A;
  localparam logic [7:0] IDX_SEC_HI   = 8'h6B;
  localparam logic [7:0] IDX_IRQ_STAT = 8'h70;
  localparam logic [7:0] IDX_IRQ_CLR  = 8'h71;
  localparam logic [7:0] IDX_IRQ_EN   = 8'h72;
  localparam logic [7:0] IDX_STATE    = 8'h73;

  // Reset values and the ceiling that clamps silence limit writes
  localparam logic [7:0]  RST_PRIM_LO = 8'h0E;
  localparam logic [15:0] RST_SILENCE = 16'h03E8;
  localparam logic [7:0]  RST_FLAGS   = 8'h00;
  localparam logic [7:0]  RST_HOLD    = 8'h00;
  localparam logic [7:0]  RST_PRIM_HI = 8'h00;
  localparam logic [7:0]  RST_SEC_LO  = 8'h00;
  localparam logic [7:0]  RST_SEC_HI  = 8'h00;
  localparam logic [15:0] SILENCE_MAX = 16'hEA60;

  // Field positions
  localparam int unsigned PART_W        = 7;
  localparam int unsigned NODE_W        = 14;
  localparam int unsigned FLG_CMD_CHK   = 0;
  localparam int unsigned FLG_REPLY_CHK = 1;
  localparam int unsigned FLG_HIBIT_CLR = 2;
  localparam int unsigned FLG_WIDE      = 3;
  localparam int unsigned SEC_EN_BIT    = 7;
  localparam int unsigned IRQ_W         = 3;
  localparam int unsigned IRQ_ACCEPT    = 0;
  localparam int unsigned IRQ_CHK_ERR   = 1;
  localparam int unsigned IRQ_TIMEOUT   = 2;

  // Framing
  localparam logic [7:0] FRAME_START    = 8'hAA;
  localparam logic [7:0] CHK_POLY       = 8'h91;
  localparam logic [7:0] REPLY_CHK_MAX  = 8'd14;
  localparam logic [2:0] GROUP_LAST     = 3'd6;

  typedef struct packed {
    logic [7:0] data;
    logic       last;
  } saf_byte_s;

  // One byte step of the 7-bit check value
  function automatic logic [7:0] chk_step(input logic [7:0] crc,
                                          input logic [7:0] b);
    logic [7:0] c;
    c = crc ^ b;
    for (int i = 0; i < 8; i++) begin
      if (c[0]) begin
        c = c ^ CHK_POLY;
      end
      c = c >> 1;
    end
    return c;
  endfunction : chk_step

endpackage : saf_pkg

// File: hdl/saf_holdoff_timer.sv
// Retriggerable microsecond hold-off timer giving one done pulse after the latest start
`timescale 1ns/100ps
`default_nettype none
module saf_holdoff_timer (
  // Clock and reset
  input  wire logic       mclk_i,
  input  wire logic       rst_b_i,
  // Control
  input  wire logic       start_i,
  input  wire logic [7:0] delay_us_i,
  output logic            done_o
);
  logic [15:0] left_q;
  logic        busy_q;
  logic [15:0] need_q;
  logic [15:0] seen_q;

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      left_q <= 16'h0000;
      busy_q <= 1'b0;
      done_o <= 1'b0;
    end else if (start_i) begin
      left_q <= 16'(delay_us_i * saf_pkg::CYC_PER_US);
      busy_q <= 1'b1;
      done_o <= 1'b0;
    end else if (busy_q && left_q <= 16'h0001) begin
      busy_q <= 1'b0;
      done_o <= 1'b1;
    end else begin
      left_q <= busy_q ? left_q - 16'h0001 : left_q;
      done_o <= 1'b0;
    end
  end

  // Helper for the check below
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      need_q <= 16'h0000;
      seen_q <= 16'h0000;
    end else if (start_i) begin
      need_q <= 16'(delay_us_i * saf_pkg::CYC_PER_US);
      seen_q <= 16'h0000;
    end else if (seen_q != 16'hFFFF) begin
      seen_q <= seen_q + 16'h0001;
    end
  end

  property p_wait_long_enough;
    @(posedge mclk_i) disable iff (!rst_b_i)
      done_o |-> seen_q >= need_q;
  endproperty
  a_wait_long_enough: assert property (p_wait_long_enough)
    else $error("hold-off ended before the configured delay");

endmodule : saf_holdoff_timer
`default_nettype wire

// File: hdl/saf_serial_frame_cfg.sv
// Serial addressing, framing checks, reply shaping and settings registers
//
// Chosen here: register access over APB.
`timescale 1ns/100ps
`default_nettype none
module saf_serial_frame_cfg #(
  parameter int unsigned CYC_PER_MS = saf_pkg::CYC_PER_MS
) (
  // Clock and reset
  input  wire logic              mclk_i,
  input  wire logic              rst_b_i,
  // APB slave
  input  wire logic              psel_i,
  input  wire logic              penable_i,
  input  wire logic              pwrite_i,
  input  wire logic [11:0]       paddr_i,
  input  wire logic [31:0]       pwdata_i,
  output logic      [31:0]       prdata_o,
  output logic                   pready_o,
  output logic                   pslverr_o,
  // Received command bytes
  input  wire logic              rx_valid_i,
  input  wire saf_pkg::saf_byte_s rx_byte_i,
  // Checked command stream
  output logic                   cmd_valid_o,
  output var saf_pkg::saf_byte_s cmd_byte_o,
  output logic                   cmd_accept_o,
  output logic                   cmd_drop_o,
  // Reply bytes in
  input  wire logic              reply_valid_i,
  input  wire saf_pkg::saf_byte_s reply_byte_i,
  output logic                   reply_ready_o,
  // Serial transmit bytes out
  output logic                   tx_valid_o,
  output logic      [7:0]        tx_data_o,
  input  wire logic              tx_ready_i,
  // I2C byte pacing
  input  wire logic              i2c_byte_i,
  output logic                   i2c_go_o,
  output logic      [6:0]        i2c_addr_o,
  // Status
  output logic                   timeout_err_o,
  output logic                   irq_o
);
  typedef enum logic [4:0] {
    P_IDLE = 5'b00001, P_ADDR_LO = 5'b00010, P_ADDR_HI = 5'b00100,
    P_BODY = 5'b01000, P_SKIP = 5'b10000
  } saf_parse_e;
  typedef enum logic [4:0] {
    R_IDLE = 5'b00001, R_WAIT = 5'b00010, R_DATA = 5'b00100,
    R_MSB  = 5'b01000, R_CHK  = 5'b10000
  } saf_reply_e;

  logic [7:0]  prim_lo_q, prim_hi_q, sec_lo_q, sec_hi_q, flags_q, hold_q;
  logic [15:0] silence_q;
  logic [2:0]  irq_stat_q, irq_en_q, ev, clr_mask;
  logic [13:0] prim_id, sec_id, rx_id;
  logic        sec_en;
  logic [7:0]  idx;
  logic        setup, wr_go, hit;
  logic [31:0] rd_val;
  saf_parse_e  p_st_q;
  logic        wide_q, chk_req_q, match_q, prim_hit_q;
  logic [6:0]  addr_lo_q;
  logic [7:0]  body_cnt_q, cmd_crc_q;
  logic        accept_d, chk_drop_d;
  logic [16:0] ms_div_q;
  logic [15:0] elapsed_q;
  logic        limit_hit;
  saf_reply_e  r_st_q, r_st_d;
  logic        rchk_q, hibit_q, last_q, take_r, emit, slot_free, t_start;
  logic        t_done;
  logic [7:0]  emit_byte, r_crc_q, r_cnt_q;
  logic [2:0]  grp_q;
  logic [6:0]  msb_q;

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);

  assign prim_id = {prim_hi_q[6:0], prim_lo_q[6:0]};
  assign sec_id  = {sec_hi_q[6:0], sec_lo_q[6:0]};
  assign sec_en  = sec_lo_q[saf_pkg::SEC_EN_BIT];

  // APB decode
  assign idx   = paddr_i[9:2];
  assign setup = psel_i & ~penable_i;
  assign wr_go = psel_i & penable_i & pready_o & pwrite_i & ~pslverr_o;

  always_comb begin
    hit    = (paddr_i[11:10] == 2'b00) && (paddr_i[1:0] == 2'b00);
    rd_val = 32'h0000_0000;
    unique case (idx)
      saf_pkg::IDX_PRIM_LO:  rd_val[7:0]  = prim_lo_q;
      saf_pkg::IDX_SILENCE:  rd_val[15:0] = silence_q;
      saf_pkg::IDX_FLAGS:    rd_val[7:0]  = flags_q;
      saf_pkg::IDX_HOLD:     rd_val[7:0]  = hold_q;
      saf_pkg::IDX_PRIM_HI:  rd_val[7:0]  = prim_hi_q;
      saf_pkg::IDX_SEC_LO:   rd_val[7:0]  = sec_lo_q;
      saf_pkg::IDX_SEC_HI:   rd_val[7:0]  = sec_hi_q;
      saf_pkg::IDX_IRQ_STAT: rd_val[2:0]  = irq_stat_q;
      saf_pkg::IDX_IRQ_CLR:  rd_val       = 32'h0000_0000;
      saf_pkg::IDX_IRQ_EN:   rd_val[2:0]  = irq_en_q;
      saf_pkg::IDX_STATE:    rd_val[16:0] = {timeout_err_o, elapsed_q};
      default:               hit          = 1'b0;
    endcase
  end

  // Bus answer one cycle after setup
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o  <= 32'h0000_0000;
    end else begin
      pready_o  <= setup;
      pslverr_o <= setup & ~hit;
      if (setup && !pwrite_i) begin
        prdata_o <= hit ? rd_val : 32'h0000_0000;
      end
    end
  end

  // Settings registers
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      prim_lo_q <= saf_pkg::RST_PRIM_LO;
      silence_q <= saf_pkg::RST_SILENCE;
      flags_q   <= saf_pkg::RST_FLAGS;
      hold_q    <= saf_pkg::RST_HOLD;
      prim_hi_q <= saf_pkg::RST_PRIM_HI;
      sec_lo_q  <= saf_pkg::RST_SEC_LO;
      sec_hi_q  <= saf_pkg::RST_SEC_HI;
      irq_en_q  <= 3'h0;
    end else if (wr_go) begin
      unique case (idx)
        saf_pkg::IDX_PRIM_LO: prim_lo_q <= pwdata_i[7:0];
        saf_pkg::IDX_SILENCE: silence_q <=
          (pwdata_i[15:0] > saf_pkg::SILENCE_MAX) ?
          saf_pkg::SILENCE_MAX : pwdata_i[15:0];
        saf_pkg::IDX_FLAGS:   flags_q   <= pwdata_i[7:0];
        saf_pkg::IDX_HOLD:    hold_q    <= pwdata_i[7:0];
        saf_pkg::IDX_PRIM_HI: prim_hi_q <= pwdata_i[7:0];
        saf_pkg::IDX_SEC_LO:  sec_lo_q  <= pwdata_i[7:0];
        saf_pkg::IDX_SEC_HI:  sec_hi_q  <= pwdata_i[7:0];
        saf_pkg::IDX_IRQ_EN:  irq_en_q  <= pwdata_i[2:0];
        default: ;
      endcase
    end
  end

  // Interrupt status; a new event beats a clear
  assign clr_mask = (wr_go && idx == saf_pkg::IDX_IRQ_CLR) ?
                    pwdata_i[2:0] : 3'h0;
  assign ev[saf_pkg::IRQ_ACCEPT]  = accept_d;
  assign ev[saf_pkg::IRQ_CHK_ERR] = chk_drop_d;
  assign ev[saf_pkg::IRQ_TIMEOUT] = limit_hit & ~timeout_err_o & ~accept_d;

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      irq_stat_q <= 3'h0;
      irq_o      <= 1'b0;
    end else begin
      irq_stat_q <= (irq_stat_q & ~clr_mask) | ev;
      irq_o      <= |(irq_stat_q & irq_en_q);
    end
  end

  // Command parser
  assign rx_id = (p_st_q == P_ADDR_HI) ?
                 {rx_byte_i.data[6:0], addr_lo_q} :
                 {7'h00, rx_byte_i.data[6:0]};

  always_comb begin
    accept_d   = 1'b0;
    chk_drop_d = 1'b0;
    if (rx_valid_i && rx_byte_i.last && p_st_q == P_BODY && match_q) begin
      if (!chk_req_q) begin
        accept_d = 1'b1;
      end else if (body_cnt_q != 8'h00 && !rx_byte_i.data[7] &&
                   rx_byte_i.data == cmd_crc_q) begin
        accept_d = 1'b1;
      end else begin
        chk_drop_d = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      p_st_q     <= P_IDLE;
      wide_q     <= 1'b0;
      chk_req_q  <= 1'b0;
      match_q    <= 1'b0;
      prim_hit_q <= 1'b0;
      addr_lo_q  <= 7'h00;
      body_cnt_q <= 8'h00;
      cmd_crc_q  <= 8'h00;
    end else if (rx_valid_i) begin
      cmd_crc_q <= saf_pkg::chk_step(cmd_crc_q, rx_byte_i.data);
      unique case (p_st_q)
        P_IDLE: begin
          cmd_crc_q  <= saf_pkg::chk_step(8'h00, rx_byte_i.data);
          wide_q     <= flags_q[saf_pkg::FLG_WIDE];
          chk_req_q  <= flags_q[saf_pkg::FLG_CMD_CHK];
          body_cnt_q <= 8'h00;
          if (!rx_byte_i.last) begin
            p_st_q <= (rx_byte_i.data == saf_pkg::FRAME_START) ?
                      P_ADDR_LO : P_SKIP;
          end
        end
        P_ADDR_LO, P_ADDR_HI: begin
          addr_lo_q  <= rx_byte_i.data[6:0];
          prim_hit_q <= rx_id == prim_id;
          match_q    <= (rx_id == prim_id) ||
                        (sec_en && rx_id == sec_id);
          if (rx_byte_i.last) begin
            p_st_q <= P_IDLE;
          end else if (p_st_q == P_ADDR_LO && wide_q) begin
            p_st_q <= P_ADDR_HI;
          end else begin
            p_st_q <= P_BODY;
          end
        end
        P_BODY: begin
          if (body_cnt_q != 8'hFF) begin
            body_cnt_q <= body_cnt_q + 8'h01;
          end
          p_st_q <= rx_byte_i.last ? P_IDLE : P_BODY;
        end
        P_SKIP: p_st_q <= rx_byte_i.last ? P_IDLE : P_SKIP;
      endcase
    end
  end

  // Forward body bytes of matching frames; mismatches stay silent
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cmd_valid_o  <= 1'b0;
      cmd_byte_o   <= '0;
      cmd_accept_o <= 1'b0;
      cmd_drop_o   <= 1'b0;
    end else begin
      cmd_valid_o  <= rx_valid_i && p_st_q == P_BODY && match_q &&
                      !(rx_byte_i.last && chk_req_q);
      cmd_byte_o   <= rx_byte_i;
      cmd_accept_o <= accept_d;
      cmd_drop_o   <= chk_drop_d;
    end
  end

  // Silence watchdog in milliseconds
  assign limit_hit = (silence_q != 16'h0000) && (elapsed_q >= silence_q);

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ms_div_q      <= 17'h00000;
      elapsed_q     <= 16'h0000;
      timeout_err_o <= 1'b0;
    end else if (accept_d) begin
      ms_div_q      <= 17'h00000;
      elapsed_q     <= 16'h0000;
      timeout_err_o <= 1'b0;
    end else begin
      if (ms_div_q == 17'(CYC_PER_MS - 1)) begin
        ms_div_q  <= 17'h00000;
        elapsed_q <= (elapsed_q == 16'hFFFF) ? elapsed_q :
                     elapsed_q + 16'h0001;
      end else begin
        ms_div_q <= ms_div_q + 17'h00001;
      end
      if (limit_hit) begin
        timeout_err_o <= 1'b1;
      end
    end
  end

  // Reply shaping
  assign slot_free = ~tx_valid_o | tx_ready_i;
  assign take_r    = reply_valid_i & reply_ready_o;

  always_comb begin
    r_st_d    = r_st_q;
    emit      = 1'b0;
    emit_byte = 8'h00;
    t_start   = 1'b0;
    unique case (r_st_q)
      R_IDLE: begin
        // Older reply bytes leave before new flags are latched
        if (reply_valid_i && slot_free) begin
          r_st_d  = R_WAIT;
          t_start = 1'b1;
        end
      end
      R_WAIT: r_st_d = t_done ? R_DATA : R_WAIT;
      R_DATA: begin
        if (take_r) begin
          emit      = 1'b1;
          emit_byte = hibit_q ? {1'b0, reply_byte_i.data[6:0]} :
                      reply_byte_i.data;
          if (hibit_q && (grp_q == saf_pkg::GROUP_LAST ||
                          reply_byte_i.last)) begin
            r_st_d = R_MSB;
          end else if (reply_byte_i.last) begin
            r_st_d = (rchk_q && r_cnt_q < saf_pkg::REPLY_CHK_MAX) ?
                     R_CHK : R_IDLE;
          end
        end
      end
      R_MSB: begin
        if (slot_free) begin
          emit      = 1'b1;
          emit_byte = {1'b0, msb_q};
          if (last_q) begin
            r_st_d = (rchk_q && r_cnt_q < saf_pkg::REPLY_CHK_MAX) ?
                     R_CHK : R_IDLE;
          end else begin
            r_st_d = R_DATA;
          end
        end
      end
      R_CHK: begin
        if (slot_free) begin
          emit      = 1'b1;
          emit_byte = r_crc_q;
          r_st_d    = R_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      r_st_q        <= R_IDLE;
      rchk_q        <= 1'b0;
      hibit_q       <= 1'b0;
      last_q        <= 1'b0;
      r_crc_q       <= 8'h00;
      r_cnt_q       <= 8'h00;
      grp_q         <= 3'h0;
      msb_q         <= 7'h00;
      tx_valid_o    <= 1'b0;
      tx_data_o     <= 8'h00;
      reply_ready_o <= 1'b0;
    end else begin
      r_st_q        <= r_st_d;
      reply_ready_o <= (r_st_d == R_DATA) && !take_r && slot_free;
      if (emit) begin
        tx_valid_o <= 1'b1;
        tx_data_o  <= emit_byte;
        r_crc_q    <= saf_pkg::chk_step(r_crc_q, emit_byte);
        r_cnt_q    <= (r_cnt_q == 8'hFF) ? r_cnt_q : r_cnt_q + 8'h01;
      end else if (tx_ready_i) begin
        tx_valid_o <= 1'b0;
      end
      if (t_start) begin
        rchk_q  <= flags_q[saf_pkg::FLG_REPLY_CHK];
        hibit_q <= flags_q[saf_pkg::FLG_HIBIT_CLR];
        r_crc_q <= 8'h00;
        r_cnt_q <= 8'h00;
        grp_q   <= 3'h0;
        msb_q   <= 7'h00;
        last_q  <= 1'b0;
      end else if (take_r) begin
        last_q           <= reply_byte_i.last;
        msb_q[grp_q]     <= reply_byte_i.data[7];
        grp_q            <= grp_q + 3'h1;
      end else if (r_st_q == R_MSB && emit) begin
        grp_q <= 3'h0;
        msb_q <= 7'h00;
      end
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      i2c_addr_o <= 7'h00;
    end else begin
      i2c_addr_o <= prim_id[6:0];
    end
  end

  saf_holdoff_timer u_reply_wait (
    .mclk_i     (mclk_i),
    .rst_b_i    (rst_b_i),
    .start_i    (t_start),
    .delay_us_i (hold_q),
    .done_o     (t_done)
  );

  saf_holdoff_timer u_i2c_wait (
    .mclk_i     (mclk_i),
    .rst_b_i    (rst_b_i),
    .start_i    (i2c_byte_i),
    .delay_us_i (hold_q),
    .done_o     (i2c_go_o)
  );

  // Checks
  property p_i2c_addr;
    $past(rst_b_i) |-> i2c_addr_o == $past(prim_id[6:0]);
  endproperty
  a_i2c_addr: assert property (p_i2c_addr)
    else $error("I2C address differs from node number");

  property p_accept_matched;
    cmd_accept_o |-> $past(match_q);
  endproperty
  a_accept_matched: assert property (p_accept_matched)
    else $error("command accepted without address match");

  property p_sec_off;
    (cmd_accept_o && !$past(sec_en)) |-> $past(prim_hit_q);
  endproperty
  a_sec_off: assert property (p_sec_off)
    else $error("secondary number used while disabled");

  property p_timeout_set;
    (limit_hit && !accept_d) |=> timeout_err_o;
  endproperty
  a_timeout_set: assert property (p_timeout_set)
    else $error("silence limit passed without error");

  property p_timeout_off;
    (silence_q == 16'h0000 && !timeout_err_o) |=> !timeout_err_o;
  endproperty
  a_timeout_off: assert property (p_timeout_off)
    else $error("timeout raised with limit zero");

  sequence s_narrow_addr;
    p_st_q == P_ADDR_LO && rx_valid_i && !rx_byte_i.last && !wide_q;
  endsequence
  property p_narrow_one_byte;
    s_narrow_addr |=> p_st_q == P_BODY;
  endproperty
  a_narrow_one_byte: assert property (p_narrow_one_byte)
    else $error("narrow mode expected a second address byte");

  property p_chk_bad_drops;
    (rx_valid_i && p_st_q == P_BODY && rx_byte_i.last && match_q &&
     chk_req_q && rx_byte_i.data != cmd_crc_q) |=>
      cmd_drop_o && !cmd_accept_o;
  endproperty
  a_chk_bad_drops: assert property (p_chk_bad_drops)
    else $error("bad check byte not discarded");

  property p_reply_low;
    (tx_valid_o && hibit_q) |-> !tx_data_o[7];
  endproperty
  a_reply_low: assert property (p_reply_low)
    else $error("reply byte above 0x7F in seven-bit mode");

  property p_chk_short_only;
    r_st_q == R_CHK |-> r_cnt_q <= saf_pkg::REPLY_CHK_MAX;
  endproperty
  a_chk_short_only: assert property (p_chk_short_only)
    else $error("check byte on over-long reply");

endmodule : saf_serial_frame_cfg
`default_nettype wire

// File: testbench/saf_host_model.sv
// Host side: sends command frames and sinks reply bytes
`timescale 1ns/100ps
`default_nettype none
module saf_host_model (
  // Clock
  input  wire logic               mclk_i,
  // Command bytes to the device
  output var logic                rx_valid_o,
  output var saf_pkg::saf_byte_s  rx_byte_o,
  // Reply bytes from the device
  input  wire logic               tx_valid_i,
  input  wire logic [7:0]         tx_data_i,
  output var logic                tx_ready_o
);
  logic       stall = 1'h0;
  logic [1:0] ph_q  = 2'h0;
  logic [7:0] got[$];

  initial begin
    rx_valid_o = 1'h0;
    rx_byte_o  = '0;
    tx_ready_o = 1'h0;
  end

  // Sink takes one byte in three while stall is set, every byte otherwise
  always @(posedge mclk_i) begin
    ph_q       <= (ph_q == 2'h2) ? 2'h0 : ph_q + 2'h1;
    tx_ready_o <= !stall || (ph_q == 2'h2);
    if (tx_valid_i && tx_ready_o) begin
      got.push_back(tx_data_i);
    end
  end

  // Frame bytes on consecutive cycles; line inverted once released
  task automatic send(input logic [7:0] f[$]);
    foreach (f[i]) begin
      rx_valid_o <= 1'h1;
      rx_byte_o  <= '{data: f[i], last: (i == f.size() - 1)};
      @(posedge mclk_i);
    end
    rx_valid_o <= 1'h0;
    rx_byte_o  <= ~rx_byte_o;
  endtask : send
endmodule : saf_host_model
`default_nettype wire

// File: testbench/tb_serial_addressing_and_framing_cfg.sv
// Self-checking bench of the serial framing block
`timescale 1ns/100ps
`default_nettype none
module tb_serial_addressing_and_framing_cfg;
  logic               clk = 1'h0, rst_b = 1'h0;
  logic               psel = 1'h0, pen = 1'h0, pwr = 1'h0;
  logic               rv = 1'h0, i2b = 1'h0;
  logic [11:0]        paddr = 12'h000;
  logic [31:0]        pwd = 32'h0, prd, rd;
  logic               prdy, perr, err, cv, acc, drp, rr, txv, txr, go;
  logic               tmo, irq, rxv;
  logic [7:0]         txd, last_cmd;
  logic [7:0]         q[$];
  logic [6:0]         i2a;
  saf_pkg::saf_byte_s rxb, cmdb, rb = '0;
  int                 err_count = 0, n_tests = 0, n_acc = 0, n_drp = 0, n;

  initial forever #5 clk = ~clk;

  saf_serial_frame_cfg #(.CYC_PER_MS(10)) uut (.mclk_i(clk), .rst_b_i(rst_b),
    .psel_i(psel), .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr),
    .pwdata_i(pwd), .prdata_o(prd), .pready_o(prdy), .pslverr_o(perr),
    .rx_valid_i(rxv), .rx_byte_i(rxb), .cmd_valid_o(cv), .cmd_byte_o(cmdb),
    .cmd_accept_o(acc), .cmd_drop_o(drp), .reply_valid_i(rv),
    .reply_byte_i(rb), .reply_ready_o(rr), .tx_valid_o(txv),
    .tx_data_o(txd), .tx_ready_i(txr), .i2c_byte_i(i2b), .i2c_go_o(go),
    .i2c_addr_o(i2a), .timeout_err_o(tmo), .irq_o(irq));
  saf_host_model host (.mclk_i(clk), .rx_valid_o(rxv), .rx_byte_o(rxb),
    .tx_valid_i(txv), .tx_data_i(txd), .tx_ready_o(txr));

  always @(posedge clk) begin
    n_acc += (acc === 1'h1);
    n_drp += (drp === 1'h1);
    if (cv === 1'h1) last_cmd = cmdb.data;
  end

  task automatic chk(input string s, input logic [31:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", s, exp, seen);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] d);
    psel  <= 1'h1;
    pwr   <= w;
    paddr <= {2'h0, idx, 2'h0};
    pwd   <= d;
    @(posedge clk);
    pen <= 1'h1;
    do @(posedge clk); while (prdy !== 1'h1);
    rd = prd;
    err = perr;
    psel <= 1'h0;
    pen  <= 1'h0;
    @(posedge clk);
  endtask : apb

  function automatic logic [7:0] crc(input logic [7:0] f[$]);
    logic [7:0] c;
    c = 8'h00;
    foreach (f[i]) begin
      c = c ^ f[i];
      repeat (8) c = c[0] ? (c ^ 8'h91) >> 1 : c >> 1;
    end
    return c;
  endfunction : crc

  task automatic frame(input logic [7:0] f[$], input int a, input int dr);
    int a0, d0;
    a0 = n_acc;
    d0 = n_drp;
    host.send(f);
    repeat (3) @(posedge clk);
    chk("accepts", n_acc - a0, a);
    chk("drops", n_drp - d0, dr);
  endtask : frame

  task automatic reply(input logic [7:0] b, input logic l);
    n = 0;
    rv <= 1'h1;
    rb <= '{data: b, last: l};
    do begin
      @(posedge clk);
      n++;
    end while (rr !== 1'h1);
    rv <= 1'h0;
    rb <= ~rb;
    @(posedge clk);
  endtask : reply

  task automatic tx_is(input logic [7:0] e[$]);
    while (host.got.size() < e.size()) @(posedge clk);
    foreach (e[i]) chk("tx_byte", host.got[i], e[i]);
    host.got.delete();
  endtask : tx_is

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : complete_run

  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    complete_run();
  end

  initial begin
    repeat (10) @(posedge clk);
    rst_b <= 1'h1;
    @(posedge clk);
    apb(1'h0, saf_pkg::IDX_PRIM_LO, 32'h0);
    chk("prim_lo", rd, 32'h0000000E);
    chk("i2c_addr", i2a, 32'h0000000E);
    apb(1'h0, saf_pkg::IDX_SILENCE, 32'h0);
    chk("silence", rd, 32'h000003E8);
    apb(1'h0, saf_pkg::IDX_SEC_LO, 32'h0);
    chk("sec_lo", rd, 32'h00000000);
    frame('{8'hAA, 8'h0E, 8'h55}, 1, 0);
    chk("cmd_byte", last_cmd, 32'h00000055);
    frame('{8'hAA, 8'h05, 8'h55}, 0, 0);
    apb(1'h1, saf_pkg::IDX_SEC_LO, 32'h05);
    frame('{8'hAA, 8'h05, 8'h55}, 0, 0);
    apb(1'h1, saf_pkg::IDX_SEC_LO, 32'h85);
    frame('{8'hAA, 8'h05, 8'h55}, 1, 0);
    frame('{8'hAA, 8'h0E, 8'h55}, 1, 0);
    apb(1'h1, saf_pkg::IDX_PRIM_HI, 32'h01);
    apb(1'h1, saf_pkg::IDX_FLAGS, 32'h08);
    frame('{8'hAA, 8'h0E, 8'h01, 8'h33}, 1, 0);
    frame('{8'hAA, 8'h0E, 8'h33, 8'h44}, 0, 0);
    apb(1'h1, saf_pkg::IDX_PRIM_HI, 32'h00);
    apb(1'h1, saf_pkg::IDX_FLAGS, 32'h01);
    q = '{8'hAA, 8'h0E, 8'h12};
    frame({q, crc(q)}, 1, 0);
    frame({q, crc(q) ^ 8'h01}, 0, 1);
    frame(q, 0, 1);
    apb(1'h1, saf_pkg::IDX_FLAGS, 32'h00);
    apb(1'h1, saf_pkg::IDX_SILENCE, 32'h02);
    repeat (40) @(posedge clk);
    chk("timeout", tmo, 32'h1);
    apb(1'h0, saf_pkg::IDX_IRQ_STAT, 32'h0);
    chk("stat_tmo", rd[2], 32'h1);
    apb(1'h0, saf_pkg::IDX_STATE, 32'h0);
    chk("state_tmo", rd[16], 32'h1);
    apb(1'h1, saf_pkg::IDX_IRQ_EN, 32'h04);
    @(posedge clk);
    chk("irq", irq, 32'h1);
    apb(1'h1, saf_pkg::IDX_SILENCE, 32'h00);
    frame('{8'hAA, 8'h0E, 8'h55}, 1, 0);
    apb(1'h1, saf_pkg::IDX_IRQ_CLR, 32'h07);
    repeat (30) @(posedge clk);
    chk("timeout_off", tmo, 32'h0);
    chk("irq_off", irq, 32'h0);
    apb(1'h1, saf_pkg::IDX_SILENCE, 32'h0000FDE8);
    apb(1'h0, saf_pkg::IDX_SILENCE, 32'h0);
    chk("silence_max", rd, 32'h0000EA60);
    apb(1'h1, saf_pkg::IDX_HOLD, 32'h01);
    i2b <= 1'h1;
    @(posedge clk);
    i2b <= 1'h0;
    n = 0;
    while (go !== 1'h1) begin
      @(posedge clk);
      n++;
    end
    chk("i2c_hold", n >= 99, 32'h1);
    apb(1'h1, saf_pkg::IDX_FLAGS, 32'h04);
    host.stall <= 1'h1;
    reply(8'h81, 1'h0);
    chk("reply_hold", n >= 100, 32'h1);
    reply(8'h02, 1'h1);
    tx_is('{8'h01, 8'h02, 8'h01});
    host.stall <= 1'h0;
    apb(1'h1, saf_pkg::IDX_HOLD, 32'h00);
    apb(1'h1, saf_pkg::IDX_FLAGS, 32'h02);
    reply(8'h11, 1'h1);
    tx_is('{8'h11, crc('{8'h11})});
    apb(1'h0, 8'h40, 32'h0);
    chk("unmapped_err", err, 32'h1);
    chk("unmapped_rd", rd, 32'h0);
    complete_run();
  end
endmodule : tb_serial_addressing_and_framing_cfg
`default_nettype wire
